// file: cpq_consts.svh
// Purpose: Constants for the charger power-up input qualifier
// Assumes: 50 MHz clock
// Notes:   Register offsets are byte addresses on AHB-Lite
`ifndef CPQ_CONSTS_SVH
`define CPQ_CONSTS_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CPQ_OFF_INCTL   12'h000
`define CPQ_OFF_SYSCTL  12'h004
`define CPQ_OFF_WDCTL   12'h008
`define CPQ_OFF_MISC    12'h00C
`define CPQ_OFF_STATUS  12'h010
`define CPQ_OFF_ANALOG  12'h014
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CPQ_B_HIZ       7
`define CPQ_B_REGRST    7
`define CPQ_B_FORCEDET  7
`define CPQ_B_BSWOFF    5
`define CPQ_B_PG        2
`define CPQ_B_WD_LO     4
`define CPQ_B_ST_LO     6
// ----------------------------------------------------------------------
// Field values
// ----------------------------------------------------------------------
`define CPQ_LIM_100     3'h0
`define CPQ_LIM_500     3'h2
`define CPQ_LIM_3A      3'h7
`define CPQ_ST_NONE     2'h0
`define CPQ_ST_USB      2'h1
`define CPQ_ST_ADAPT    2'h2
`define CPQ_WD_OFF      2'h0
`define CPQ_WD_DFLT     2'h1
`define CPQ_INCTL_RST   8'h00
// ----------------------------------------------------------------------
// Times and cycle counts at 50 MHz
// ----------------------------------------------------------------------
`define CPQ_CLK_HZ      50000000
`define CPQ_QUAL_MS     100
`define CPQ_RETRY_MS    2000
`define CPQ_WAKE_MS     2
`define CPQ_WDT_S       40
`define CPQ_WAKE_CYC    (`CPQ_WAKE_MS * (`CPQ_CLK_HZ / 1000))
`define CPQ_QUAL_CYC    (`CPQ_QUAL_MS * (`CPQ_CLK_HZ / 1000))
`define CPQ_RETRY_CYC   (`CPQ_RETRY_MS * (`CPQ_CLK_HZ / 1000))
`define CPQ_WDT_CYC     (`CPQ_WDT_S * `CPQ_CLK_HZ)
`endif

// file: cpq_host_model.sv
// Purpose: Host processor and PHY select pins facing the qualifier
// Assumes: Zero or more wait states, single word transfers
// Notes:   Released write data is inverted so stale values never match
`include "cpq_consts.svh"

module cpq_host_model (
    // Clock and bus answer
    input  wire logic        i_mclk,
    input  wire logic        i_hreadyout,
    input  wire logic [31:0] i_hrdata,
    // AHB-Lite request
    output logic             o_hsel,
    output logic      [11:0] o_haddr,
    output logic      [1:0]  o_htrans,
    output logic             o_hwrite,
    output logic      [2:0]  o_hsize,
    output logic      [31:0] o_hwdata,
    // PHY select pins
    output logic             o_port_select,
    output logic             o_otg
);
    // Idle bus and pins at time zero
    initial begin
        {o_hsel, o_haddr, o_htrans, o_hwrite, o_hsize} = '0;
        o_hwdata = 32'h0000_0000;
        {o_port_select, o_otg} = 2'h0;
    end

    // One single transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge i_mclk);
        o_hsel <= 1'b1;
        o_htrans <= 2'h2;
        o_haddr <= a;
        o_hwrite <= w;
        o_hsize <= 3'h2;
        do @(posedge i_mclk); while (i_hreadyout !== 1'b1);
        o_hsel <= 1'b0;
        o_htrans <= 2'h0;
        o_hwdata <= d;
        do @(posedge i_mclk); while (i_hreadyout !== 1'b1);
        q = i_hrdata;
        o_hwdata <= ~d;
    endtask

    // Shipping entry: watchdog off, then switch off back to back
    task automatic ship();
        logic [31:0] q;
        xfer(1'b1, `CPQ_OFF_WDCTL, 32'h0000_0000, q);
        xfer(1'b1, `CPQ_OFF_MISC, 32'h0000_0020, q);
    endtask

    // PHY select levels
    task automatic pins(input logic ps, input logic og);
        @(posedge i_mclk);
        o_port_select <= ps;
        o_otg <= og;
    endtask
endmodule

// file: cpq_pkg.sv
// Purpose: Types for the charger power-up input qualifier
// Assumes: Nothing beyond the constants header
// Notes:   States of the input sequencer
package cpq_pkg;
    typedef enum logic [2:0] {
        CPQ_IDLE,
        CPQ_QUAL_WAIT,
        CPQ_SRC_CHECK,
        CPQ_RETRY_WAIT,
        CPQ_DETECT,
        CPQ_RUN,
        CPQ_HIZ
    } cpq_state_e;
endpackage

// file: cpq_sync.sv
// Purpose: Two-stage synchroniser for a group of pin levels
// Assumes: Pins are asynchronous levels
// Notes:   First stage is read only by the second
module cpq_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_mclk,
    input  wire logic         i_rst_n,
    // Pins in, levels out
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_r;

    // Two flops per bit
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule

// file: cpq_top.sv
// Purpose: Power-up sequencing and input qualification for a charger
// Assumes: 50 MHz clock, AHB-Lite single word transfers
// Notes:   Analog comparators arrive as asynchronous levels
//
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`include "cpq_consts.svh"

module cpq_top
    import cpq_pkg::*;
#(
    parameter int QUAL_CYC  = `CPQ_QUAL_CYC,
    parameter int RETRY_CYC = `CPQ_RETRY_CYC,
    parameter int WAKE_CYC  = `CPQ_WAKE_CYC,
    parameter int WDT_CYC   = `CPQ_WDT_CYC
) (
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    // AHB-Lite slave
    input  wire logic        i_hsel,
    input  wire logic [11:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Analog comparators and pins
    input  wire logic        i_vbus_uvlo_ok,
    input  wire logic        i_bat_uvlo_ok,
    input  wire logic        i_bat_above_depl,
    input  wire logic        i_vbus_above_sleep,
    input  wire logic        i_boost_mode,
    input  wire logic        i_vbus_ovp,
    input  wire logic        i_vbus_above_poor,
    input  wire logic        i_bat_good,
    input  wire logic        i_port_select,
    input  wire logic        i_otg,
    input  wire logic        i_wake_pin,
    // Control and status outputs
    output logic             o_battery_switch_on,
    output logic             o_bias_regulator_en,
    output logic             o_test_load_en,
    output logic             o_converter_en,
    output logic             o_power_good_pin_n,
    output logic             o_host_int,
    output logic      [2:0]  o_input_limit
);
    initial begin
        if (QUAL_CYC < 1 || RETRY_CYC < 1 || WAKE_CYC < 1 || WDT_CYC < 1)
            $error("cpq_top: cycle counts must be at least one");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [10:0] pins_s;
    cpq_sync #(.W(11)) u_sync (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_async ({i_vbus_uvlo_ok, i_bat_uvlo_ok, i_bat_above_depl,
                   i_vbus_above_sleep, i_boost_mode, i_vbus_ovp,
                   i_vbus_above_poor, i_bat_good, i_port_select, i_otg,
                   i_wake_pin}),
        .o_sync  (pins_s)
    );
    wire vbus_ok   = pins_s[10];
    wire bat_ok    = pins_s[9];
    wire bat_depl  = pins_s[8];
    wire above_slp = pins_s[7];
    wire boost     = pins_s[6];
    wire ovp       = pins_s[5];
    wire above_pr  = pins_s[4];
    wire bat_gd    = pins_s[3];
    wire psel      = pins_s[2];
    wire otg_s     = pins_s[1];
    wire wake_s    = pins_s[0];

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    logic        hiz_r;
    logic [2:0]  lim_r;
    logic        bswoff_r;
    logic        forcedet_r;
    logic [1:0]  wd_r;
    logic        pg_r;
    logic [1:0]  stat_r;
    logic        host_mode_r;
    logic        int_r;
    logic        por_done_r;
    logic        vbus_prev_r;
    logic [31:0] wake_cnt_r;
    logic [31:0] wdt_cnt_r;
    logic [31:0] tmr_r;
    cpq_state_e  st_r;
    cpq_state_e  st_nxt;
    logic        ph_act_r;
    logic        ph_wr_r;
    logic [11:0] ph_addr_r;

    // Bus decode
    wire        ap_take = i_hsel && i_hready && i_htrans[1];
    wire        wr      = ph_act_r && ph_wr_r;
    wire        wr_inctl  = wr && (ph_addr_r == `CPQ_OFF_INCTL);
    wire        wr_sysctl = wr && (ph_addr_r == `CPQ_OFF_SYSCTL);
    wire        wr_wdctl  = wr && (ph_addr_r == `CPQ_OFF_WDCTL);
    wire        wr_misc   = wr && (ph_addr_r == `CPQ_OFF_MISC);
    wire        reg_rst   = wr_sysctl && i_hwdata[`CPQ_B_REGRST];
    wire        wdt_exp   = (wd_r != `CPQ_WD_OFF) && (wdt_cnt_r == 32'h0);
    wire        soft_rst  = reg_rst || wdt_exp;

    // Power-up and wake events
    wire power_up  = vbus_ok || bat_ok;
    wire vbus_rise = vbus_ok && !vbus_prev_r;
    wire vbus_fall = !vbus_ok && vbus_prev_r;
    wire wake_held = (wake_cnt_r >= 32'(WAKE_CYC));
    wire wake_evt  = wake_s && (wake_cnt_r == 32'(WAKE_CYC - 1));

    // Detection table
    function automatic logic [4:0] cpq_detect(input logic ps,
                                              input logic og);
        if (!ps)
            cpq_detect = {`CPQ_ST_ADAPT, `CPQ_LIM_3A};
        else if (og)
            cpq_detect = {`CPQ_ST_USB, `CPQ_LIM_500};
        else
            cpq_detect = {`CPQ_ST_USB, `CPQ_LIM_100};
    endfunction
    wire [4:0] det_res = cpq_detect(psel, otg_s);
    wire       low_host = psel && !otg_s;

    // Regulator enable conditions
    wire slp_ok   = boost ? !above_slp : above_slp;
    wire reg_cond = vbus_ok && slp_ok;
    wire tmr_done = (tmr_r == 32'h0);

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            CPQ_IDLE:
                if (reg_cond) st_nxt = CPQ_QUAL_WAIT;
            CPQ_QUAL_WAIT:
                if (tmr_done) st_nxt = CPQ_SRC_CHECK;
            CPQ_SRC_CHECK:
                if (!ovp && above_pr) st_nxt = CPQ_DETECT;
                else st_nxt = CPQ_RETRY_WAIT;
            CPQ_RETRY_WAIT:
                if (tmr_done) st_nxt = CPQ_SRC_CHECK;
            CPQ_DETECT:
                if (low_host && bat_gd) st_nxt = CPQ_HIZ;
                else st_nxt = CPQ_RUN;
            CPQ_RUN:
                if (forcedet_r || wdt_exp) st_nxt = CPQ_DETECT;
            CPQ_HIZ:
                if (!hiz_r) st_nxt = CPQ_DETECT;
            default:
                st_nxt = CPQ_IDLE;
        endcase
        if (!reg_cond) st_nxt = CPQ_IDLE;
    end

    // Sequencer and timer
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r  <= CPQ_IDLE;
            tmr_r <= 32'h0;
        end else begin
            st_r <= st_nxt;
            if (st_nxt == CPQ_QUAL_WAIT && st_r != CPQ_QUAL_WAIT)
                tmr_r <= 32'(QUAL_CYC - 1);
            else if (st_nxt == CPQ_RETRY_WAIT && st_r != CPQ_RETRY_WAIT)
                tmr_r <= 32'(RETRY_CYC - 1);
            else if (!tmr_done)
                tmr_r <= tmr_r - 32'h1;
        end
    end

    // Bus address phase capture
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ph_act_r  <= 1'b0;
            ph_wr_r   <= 1'b0;
            ph_addr_r <= 12'h000;
        end else if (i_hready) begin
            ph_act_r  <= ap_take;
            ph_wr_r   <= i_hwrite;
            ph_addr_r <= i_haddr;
        end
    end

    // Pin edges and wake high-time counter
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vbus_prev_r <= 1'b0;
            wake_cnt_r  <= 32'h0;
            por_done_r  <= 1'b0;
        end else begin
            vbus_prev_r <= vbus_ok;
            por_done_r  <= power_up;
            if (!wake_s)
                wake_cnt_r <= 32'h0;
            else if (!wake_held)
                wake_cnt_r <= wake_cnt_r + 32'h1;
        end
    end

    // Host mode and watchdog
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            host_mode_r <= 1'b0;
            wdt_cnt_r   <= 32'(WDT_CYC - 1);
        end else begin
            if (soft_rst)
                host_mode_r <= 1'b0;
            else if (ph_act_r)
                host_mode_r <= 1'b1;
            if (ph_act_r || wdt_exp)
                wdt_cnt_r <= 32'(WDT_CYC - 1);
            else if (wd_r != `CPQ_WD_OFF)
                wdt_cnt_r <= wdt_cnt_r - 32'h1;
        end
    end

    // Control registers
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hiz_r      <= 1'b0;
            lim_r      <= `CPQ_LIM_100;
            bswoff_r   <= 1'b0;
            forcedet_r <= 1'b0;
            wd_r       <= `CPQ_WD_DFLT;
        end else if (reg_rst || (power_up && !por_done_r)) begin
            hiz_r      <= 1'b0;
            lim_r      <= `CPQ_LIM_100;
            bswoff_r   <= 1'b0;
            forcedet_r <= 1'b0;
            wd_r       <= `CPQ_WD_DFLT;
        end else begin
            if (wr_inctl) begin
                hiz_r <= i_hwdata[`CPQ_B_HIZ];
                lim_r <= i_hwdata[2:0];
            end
            if (st_nxt == CPQ_HIZ && st_r == CPQ_DETECT)
                hiz_r <= 1'b1;
            else if (!host_mode_r && vbus_fall)
                hiz_r <= 1'b0;
            if (st_r == CPQ_DETECT || forcedet_r || wdt_exp)
                lim_r <= (st_r == CPQ_DETECT) ? det_res[2:0]
                                              : `CPQ_LIM_100;
            if (wr_misc)
                bswoff_r <= i_hwdata[`CPQ_B_BSWOFF];
            if (vbus_rise || wdt_exp || wake_evt)
                bswoff_r <= 1'b0;
            if (wr_misc && i_hwdata[`CPQ_B_FORCEDET] && vbus_ok)
                forcedet_r <= 1'b1;
            else if (st_r == CPQ_DETECT)
                forcedet_r <= 1'b0;
            if (wr_wdctl)
                wd_r <= i_hwdata[`CPQ_B_WD_LO +: 2];
            else if (wdt_exp)
                wd_r <= `CPQ_WD_DFLT;
        end
    end

    // Status, power-good and interrupt
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pg_r   <= 1'b0;
            stat_r <= `CPQ_ST_NONE;
            int_r  <= 1'b0;
        end else begin
            int_r <= 1'b0;
            if (st_r == CPQ_SRC_CHECK && st_nxt == CPQ_DETECT) begin
                pg_r  <= 1'b1;
                int_r <= 1'b1;
            end else if (st_nxt == CPQ_IDLE)
                pg_r <= 1'b0;
            if (st_r == CPQ_DETECT)
                stat_r <= det_res[4:3];
            else if (!vbus_ok)
                stat_r <= `CPQ_ST_NONE;
        end
    end

    // Read mux, registered data
    wire [31:0] rd_inctl  = {24'h0, hiz_r, 4'h0, lim_r};
    wire [31:0] rd_misc   = {24'h0, forcedet_r, 1'b0, bswoff_r, 5'h0};
    wire [31:0] rd_wdctl  = {26'h0, wd_r, 4'h0};
    wire [31:0] rd_status = {24'h0, stat_r, 3'h0, pg_r, 2'h0};
    wire [31:0] rd_analog = {20'h0, host_mode_r, st_r, 8'h0};
    wire [31:0] rd_mux =
        (i_haddr == `CPQ_OFF_INCTL)  ? rd_inctl  :
        (i_haddr == `CPQ_OFF_MISC)   ? rd_misc   :
        (i_haddr == `CPQ_OFF_WDCTL)  ? rd_wdctl  :
        (i_haddr == `CPQ_OFF_STATUS) ? rd_status :
        (i_haddr == `CPQ_OFF_ANALOG) ? rd_analog : 32'h0;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n)
            o_hrdata <= 32'h0;
        else if (ap_take && !i_hwrite)
            o_hrdata <= rd_mux;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign o_battery_switch_on = bat_depl && !bswoff_r;
    assign o_bias_regulator_en = (st_r != CPQ_IDLE) &&
                                 (st_r != CPQ_QUAL_WAIT) &&
                                 (st_r != CPQ_HIZ);
    assign o_test_load_en      = (st_r == CPQ_SRC_CHECK);
    assign o_converter_en      = (st_r == CPQ_RUN);
    assign o_power_good_pin_n  = !pg_r;
    assign o_host_int          = int_r;
    assign o_input_limit       = lim_r;
endmodule

// file: cpq_top_assertions.sv
// Purpose: Port-level checks of the power-up input qualifier
// Assumes: Bound to every cpq_top instance
// Notes:   Qualification time is counted on the raw comparator levels
`include "cpq_consts.svh"

module cpq_top_chk #(
    parameter int QUAL_CYC = 8
) (
    // Clock and reset
    input wire logic       i_mclk,
    input wire logic       i_rst_n,
    // Watched inputs
    input wire logic       i_vbus_uvlo_ok,
    input wire logic       i_vbus_above_sleep,
    input wire logic       i_boost_mode,
    input wire logic       i_port_select,
    input wire logic       i_otg,
    // Watched outputs
    input wire logic       o_hreadyout,
    input wire logic       o_hresp,
    input wire logic       o_bias_regulator_en,
    input wire logic       o_test_load_en,
    input wire logic       o_converter_en,
    input wire logic       o_power_good_pin_n,
    input wire logic       o_host_int,
    input wire logic [2:0] o_input_limit
);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic [31:0] qual_r;
    wire        qual_ok = i_vbus_uvlo_ok &&
                          (i_vbus_above_sleep != i_boost_mode);
    wire  [2:0] exp_lim = i_port_select ? (i_otg ? `CPQ_LIM_500 : `CPQ_LIM_100)
                                        : `CPQ_LIM_3A;

    // Cycles the input has met the enable conditions, saturating
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n)
            qual_r <= 32'h0;
        else if (!qual_ok)
            qual_r <= 32'h0;
        else if (qual_r != 32'hFFFF_FFFF)
            qual_r <= qual_r + 32'h1;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    ready_okay_a: assert property (o_hreadyout && !o_hresp)
        else $error("bus not ready or response not OKAY");
    reg_delay_a: assert property (
        $rose(o_bias_regulator_en) |-> qual_r >= QUAL_CYC)
        else $error("regulator on before qualification delay");
    reg_drop_a: assert property (
        $fell(i_vbus_uvlo_ok) |-> ##[1:4] !o_bias_regulator_en)
        else $error("regulator stays on without input");
    conv_reg_a: assert property (
        o_converter_en |-> o_bias_regulator_en)
        else $error("converter on with regulator off");
    load_pulse_a: assert property (
        o_test_load_en |-> o_bias_regulator_en ##1 !o_test_load_en)
        else $error("test load longer than one cycle or unbiased");
    int_pulse_a: assert property (o_host_int |=> !o_host_int)
        else $error("interrupt pulse longer than one cycle");
    int_pg_a: assert property (
        o_host_int |-> ##[0:1] !o_power_good_pin_n)
        else $error("interrupt without power good pin low");
    limit_map_a: assert property (
        $rose(o_converter_en) |-> o_input_limit == exp_lim)
        else $error("input limit does not follow the pins");
    int_load_a: assert property (
        $rose(o_host_int) |->
            $past(o_test_load_en, 1) || $past(o_test_load_en, 2))
        else $error("interrupt without a source check");
endmodule

bind cpq_top cpq_top_chk #(.QUAL_CYC(QUAL_CYC)) u_chk (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_vbus_uvlo_ok(i_vbus_uvlo_ok),
    .i_vbus_above_sleep(i_vbus_above_sleep), .i_boost_mode(i_boost_mode),
    .i_port_select(i_port_select), .i_otg(i_otg), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .o_bias_regulator_en(o_bias_regulator_en),
    .o_test_load_en(o_test_load_en), .o_converter_en(o_converter_en),
    .o_power_good_pin_n(o_power_good_pin_n), .o_host_int(o_host_int),
    .o_input_limit(o_input_limit));

// file: cpq_top_tb_top.sv
// Purpose: Self-checking bench of the power-up input qualifier
// Assumes: Short counts by parameter
// Notes:   Outputs are read just after a rising edge
`include "cpq_consts.svh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
`define WAIT(c) for (int k = 0; k < 400 && !(c); k++) @(posedge i_mclk)

module cpq_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int QUAL = 8, RETRY = 16, WAKE = 4, WDT = 20;
    logic i_mclk = 0, i_rst_n = 0, int_seen = 0, lim0_seen = 0;
    logic vbus_ok = 0, bat_ok = 1, depl = 1, sleep = 0, ovp = 0, poor = 0;
    logic bgood = 0, wake = 0, boost = 0;
    logic [31:0] q;
    int fails = 0, cmp_count = 0, cyc = 0, gap;
    wire hsel, hwrite, psel, otg, hrdy, hresp, sw_on, reg_en, tload, conv;
    wire pg_n, hint;
    wire [11:0] haddr;
    wire [1:0] htrans;
    wire [2:0] hsize, lim;
    wire [31:0] hwdata, hrdata;

    initial forever #10 i_mclk = ~i_mclk;

    cpq_host_model host (.i_mclk(i_mclk), .i_hreadyout(hrdy),
        .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans),
        .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata),
        .o_port_select(psel), .o_otg(otg));
    cpq_top #(.QUAL_CYC(QUAL), .RETRY_CYC(RETRY), .WAKE_CYC(WAKE),
        .WDT_CYC(WDT)) DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy),
        .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
        .i_vbus_uvlo_ok(vbus_ok), .i_bat_uvlo_ok(bat_ok),
        .i_bat_above_depl(depl), .i_vbus_above_sleep(sleep),
        .i_boost_mode(boost), .i_vbus_ovp(ovp), .i_vbus_above_poor(poor),
        .i_bat_good(bgood), .i_port_select(psel), .i_otg(otg),
        .i_wake_pin(wake), .o_battery_switch_on(sw_on),
        .o_bias_regulator_en(reg_en), .o_test_load_en(tload),
        .o_converter_en(conv), .o_power_good_pin_n(pg_n),
        .o_host_int(hint), .o_input_limit(lim));

    // Cycle count, event capture and hang limit
    always @(posedge i_mclk) begin
        cyc++;
        if (hint === 1'b1) int_seen <= 1'b1;
        if (lim === 3'h0) lim0_seen <= 1'b1;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end

    task automatic t_defaults();
        host.xfer(1'b0, `CPQ_OFF_INCTL, 0, q);
        `CHK("inctl", {24'h0, `CPQ_INCTL_RST}, q);
        host.xfer(1'b0, `CPQ_OFF_WDCTL, 0, q);
        `CHK("watchdog", `CPQ_WD_DFLT, q[5:4]);
        host.xfer(1'b1, 12'h020, 32'hFFFF_FFFF, q);
        host.xfer(1'b0, 12'h020, 0, q);
        `CHK("unmapped", 32'h0000_0000, q);
        host.xfer(1'b1, `CPQ_OFF_WDCTL, 0, q);
        $display("done t_defaults");
    endtask

    task automatic t_battery();
        `CHK("switch", 1'b1, sw_on);
        `CHK("regulator", 1'b0, reg_en);
        host.ship();
        repeat (WDT + 10) @(posedge i_mclk);
        `CHK("shipping", 1'b0, sw_on);
        host.xfer(1'b1, `CPQ_OFF_MISC, 0, q);
        repeat (2) @(posedge i_mclk);
        `CHK("write zero", 1'b1, sw_on);
        host.xfer(1'b1, `CPQ_OFF_MISC, 32'h20, q);
        wake <= 1'b1;
        repeat (WAKE - 2) @(posedge i_mclk);
        wake <= 1'b0;
        repeat (2) @(posedge i_mclk);
        `CHK("short wake", 1'b0, sw_on);
        wake <= 1'b1;
        repeat (WAKE + 6) @(posedge i_mclk);
        `CHK("wake", 1'b1, sw_on);
        host.xfer(1'b0, `CPQ_OFF_MISC, 0, q);
        `CHK("wake bit", 1'b0, q[`CPQ_B_BSWOFF]);
        host.xfer(1'b1, `CPQ_OFF_MISC, 32'h20, q);
        host.xfer(1'b1, `CPQ_OFF_SYSCTL, 32'h80, q);
        host.xfer(1'b0, `CPQ_OFF_MISC, 0, q);
        `CHK("reg reset", 2'b01, {q[`CPQ_B_BSWOFF], sw_on});
        host.xfer(1'b1, `CPQ_OFF_MISC, 32'h20, q);
        repeat (WDT + 10) @(posedge i_mclk);
        `CHK("watchdog", 1'b1, sw_on);
        host.xfer(1'b0, `CPQ_OFF_ANALOG, 0, q);
        `CHK("host mode", 1'b0, q[11]);
        host.xfer(1'b1, `CPQ_OFF_WDCTL, 0, q);
        $display("done t_battery");
    endtask

    task automatic t_source();
        vbus_ok <= 1'b1;
        repeat (20) @(posedge i_mclk);
        `CHK("no sleep exit", 1'b0, reg_en);
        boost <= 1'b1;
        repeat (QUAL + 6) @(posedge i_mclk);
        `CHK("boost", 1'b1, reg_en);
        boost <= 1'b0;
        sleep <= 1'b1;
        ovp <= 1'b1;
        poor <= 1'b1;
        `WAIT(tload === 1'b1);
        gap = cyc;
        ovp <= 1'b0;
        poor <= 1'b0;
        @(posedge i_mclk);
        `WAIT(tload === 1'b1);
        gap = cyc - gap;
        `CHK("retry", 1'b1, gap >= RETRY && gap <= RETRY + QUAL + 6);
        `CHK("no start", 2'b01, {conv, pg_n});
        poor <= 1'b1;
        `WAIT(conv === 1'b1);
        `CHK("pg pin", 2'b10, {int_seen, pg_n});
        host.xfer(1'b0, `CPQ_OFF_STATUS, 0, q);
        `CHK("status", {`CPQ_ST_ADAPT, 1'b1}, {q[7:6], q[`CPQ_B_PG]});
        `CHK("limit", `CPQ_LIM_3A, lim);
        $display("done t_source");
    endtask

    task automatic t_pins();
        logic [1:0] ps [3] = '{2'b11, 2'b00, 2'b10};
        logic [2:0] el [3] = '{`CPQ_LIM_500, `CPQ_LIM_3A, `CPQ_LIM_100};
        logic [1:0] es [3] = '{`CPQ_ST_USB, `CPQ_ST_ADAPT, `CPQ_ST_USB};
        for (int i = 0; i < 3; i++) begin
            host.pins(ps[i][1], ps[i][0]);
            repeat (4) @(posedge i_mclk);
            lim0_seen = 1'b0;
            host.xfer(1'b1, `CPQ_OFF_MISC, 32'h80, q);
            for (int k = 0; k < 50; k++) begin
                host.xfer(1'b0, `CPQ_OFF_MISC, 0, q);
                if (q[`CPQ_B_FORCEDET] === 1'b0) break;
            end
            `CHK("force bit", 1'b0, q[`CPQ_B_FORCEDET]);
            `CHK("held 100", 1'b1, lim0_seen);
            `CHK("pin limit", el[i], lim);
            host.xfer(1'b0, `CPQ_OFF_STATUS, 0, q);
            `CHK("src status", es[i], q[7:6]);
        end
        host.xfer(1'b1, `CPQ_OFF_INCTL, 32'h5, q);
        repeat (2) @(posedge i_mclk);
        `CHK("host limit", 3'h5, lim);
        $display("done t_pins");
    endtask

    task automatic t_hiz();
        bgood <= 1'b1;
        host.xfer(1'b1, `CPQ_OFF_MISC, 32'h80, q);
        repeat (40) @(posedge i_mclk);
        host.xfer(1'b0, `CPQ_OFF_INCTL, 0, q);
        `CHK("hiz bit", 1'b1, q[`CPQ_B_HIZ]);
        `CHK("hiz off", 2'b00, {reg_en, conv});
        bgood <= 1'b0;
        host.xfer(1'b1, `CPQ_OFF_INCTL, 0, q);
        `WAIT(conv === 1'b1);
        `CHK("hiz left", 1'b1, conv);
        $display("done t_hiz");
    endtask

    task automatic t_dflt();
        bgood <= 1'b1;
        host.xfer(1'b1, `CPQ_OFF_WDCTL, 32'h10, q);
        repeat (WDT + 30) @(posedge i_mclk);
        `CHK("dflt hiz", 1'b0, reg_en);
        vbus_ok <= 1'b0;
        repeat (10) @(posedge i_mclk);
        host.xfer(1'b0, `CPQ_OFF_INCTL, 0, q);
        `CHK("hiz clear", 1'b0, q[`CPQ_B_HIZ]);
        host.xfer(1'b1, `CPQ_OFF_WDCTL, 0, q);
        bgood <= 1'b0;
        host.pins(1'b0, 1'b0);
        vbus_ok <= 1'b1;
        `WAIT(conv === 1'b1);
        `CHK("redetect", `CPQ_LIM_3A, lim);
        $display("done t_dflt");
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Reset, then the scenarios in order
    initial begin
        repeat (6) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        t_defaults();
        t_battery();
        t_source();
        t_pins();
        t_hiz();
        t_dflt();
        summarize();
    end
endmodule
